// [design/als_consts.svh]
`ifndef ALS_CONSTS_SVH
`define ALS_CONSTS_SVH
`define ALS_PFX_X 8'hDD
`define ALS_PFX_Y 8'hFD
`define ALS_PFX_MISC 8'hED
`define ALS_PFX_BIT 8'hCB
`define ALS_OP_BCD 8'h27
`define ALS_OP_INV 8'h2F
`define ALS_OP_SCF 8'h37
`define ALS_OP_CCF 8'h3F
`define ALS_OP_NEG 8'h44
`define ALS_OP_RRD 8'h67
`define ALS_OP_RLD 8'h6F
`define ALS_OP_AND_A 8'hA7
`define ALS_GRP_MISC 2'h0
`define ALS_GRP_ED16 2'h1
`define ALS_GRP_ALU 2'h2
`define ALS_GRP_IMM 2'h3
`define ALS_SRC_MEM 3'h6
`define ALS_LO_IMM 3'h6
`define ALS_LO_ROT 3'h7
`define ALS_LO_IDHI 2'h2
`define ALS_TOP_ROTA 3'h0
`define ALS_LO_ADD16 4'h9
`define ALS_LO_INC16 4'h3
`define ALS_LO_DEC16 4'hB
`define ALS_LO_ADC16 4'hA
`define ALS_LO_SBC16 4'h2
`define ALS_ALU_SUB 3'h2
`define ALS_ALU_ADC 3'h1
`define ALS_ALU_SBC 3'h3
`define ALS_ALU_AND 3'h4
`define ALS_ALU_XOR 3'h5
`define ALS_ALU_OR 3'h6
`define ALS_ALU_CMP 3'h7
`define ALS_ROT_RLC 3'h0
`define ALS_ROT_RRC 3'h1
`define ALS_ROT_RL 3'h2
`define ALS_ROT_RR 3'h3
`define ALS_ROT_SLA 3'h4
`define ALS_ROT_SRA 3'h5
`define ALS_ROT_SLL 3'h6
`define ALS_IDX_B 3'h0
`define ALS_IDX_C 3'h1
`define ALS_IDX_D 3'h2
`define ALS_IDX_E 3'h3
`define ALS_IDX_H 3'h4
`define ALS_IDX_L 3'h5
`define ALS_IDX_F 3'h6
`define ALS_IDX_A 3'h7
`define ALS_PAIR_BC 2'h0
`define ALS_PAIR_DE 2'h1
`define ALS_PAIR_HL 2'h2
`define ALS_T_BC 3'h0
`define ALS_T_DE 3'h1
`define ALS_T_HL 3'h2
`define ALS_T_SP 3'h3
`define ALS_T_IX 3'h4
`define ALS_T_IY 3'h5
`define ALS_LD_SP 4'h8
`define ALS_LD_IX 4'h9
`define ALS_LD_IY 4'hA
`define ALS_F_S 7
`define ALS_F_Z 6
`define ALS_F_H 4
`define ALS_F_PV 2
`define ALS_F_N 1
`define ALS_F_C 0
`define ALS_H8_BIT 4
`define ALS_H16_BIT 12
`define ALS_BCD_LO 8'h06
`define ALS_BCD_HI 8'h60
`define ALS_NIB_MAX 4'h9
`define ALS_NIB_SIX 4'h6
`define ALS_BYTE_MAX 8'h99
`define ALS_INC_OVF 8'h7F
`define ALS_DEC_OVF 8'h80
`endif

// [design/als_core.sv]
// Function
// RULE_01 - accumulator is first operand of alu ops
// RULE_02 - result to accumulator, compare keeps it
// RULE_03 - every alu op updates flags
// RULE_04 - count up/down writes back to source
// RULE_05 - index prefix, opcode, displacement, index plus offset
// RULE_06 - register alu opcode blocks 80 to BF
// RULE_07 - immediate alu opcodes C6 to FE
// RULE_08 - 8-bit count up/down opcode map
// RULE_09 - add, subtract, optional carry in
// RULE_10 - accumulator and carry utility opcodes
// RULE_11 - sign flip gives two's complement
// RULE_12 - subtract indicator flag kept
// RULE_13 - bcd correct uses subtract indicator
// RULE_14 - and with self clears carry
// RULE_15 - 16-bit add into pointer or index
// RULE_16 - 16-bit carry add/borrow subtract, all flags
// RULE_17 - 16-bit count up/down opcode map
// RULE_18 - rotates and shifts on acc, reg, memory
// RULE_19 - digit rotates between acc and memory
// RULE_20 - low bits select operand, middle bits op
// RULE_21 - customary rotate and shift opcode map
`timescale 1ns/1ps
`include "als_consts.svh"
module als_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // instruction byte stream
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    output logic byte_ready_o,
    // operand memory
    output als_pkg::als_mem_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    // register preload
    input wire logic ld_valid_i,
    input wire logic [3:0] ld_sel_i,
    input wire logic [15:0] ld_data_i,
    // state view
    output als_pkg::als_regs_t regs_o,
    output logic done_o
);
    als_pkg::als_state_t state, next_state;
    logic [7:0] r8 [0:7];
    logic [15:0] sp, ix, iy;
    logic px, py, pe, pb, next_px, next_py, next_pe, next_pb;
    logic [7:0] op, disp, opnd;
    logic w8_en, w16_en, wm_en;
    logic [2:0] w8_idx, w16_t;
    logic [7:0] w8_val, f_val, wm_val;
    logic [15:0] w16_val;

    function automatic logic [7:0] szp(input logic [7:0] v);
        logic [7:0] f;
        f = 8'h00;
        f[`ALS_F_S] = v[7];
        f[`ALS_F_Z] = (v == 8'h00);
        f[`ALS_F_PV] = ~^v;
        return f;
    endfunction : szp

    function automatic als_pkg::als_res_t alu8(input logic [2:0] k, input logic [7:0] a,
                                                input logic [7:0] b, input logic c);
        logic [8:0] s;
        logic [7:0] hx;
        logic sub, ci;
        als_pkg::als_res_t r;
        sub = (k == `ALS_ALU_SUB) || (k == `ALS_ALU_SBC) || (k == `ALS_ALU_CMP);
        ci = ((k == `ALS_ALU_ADC) || (k == `ALS_ALU_SBC)) && c;
        // binary sum or difference, carry only for the carry variants
        s = sub ? {1'b0, a} - {1'b0, b} - {8'h00, ci}
                : {1'b0, a} + {1'b0, b} + {8'h00, ci}; // RULE_09
        hx = a ^ b ^ s[7:0];
        case (k)
            `ALS_ALU_AND:
            begin
                r.res = a & b;
                r.flags = szp(r.res);
                r.flags[`ALS_F_H] = 1'b1;
            end
            `ALS_ALU_XOR:
            begin
                r.res = a ^ b;
                r.flags = szp(r.res);
            end
            `ALS_ALU_OR:
            begin
                r.res = a | b;
                r.flags = szp(r.res);
            end
            default:
            begin
                r.res = s[7:0];
                r.flags = szp(r.res);
                r.flags[`ALS_F_PV] = (sub ? (a[7] ^ b[7]) : ~(a[7] ^ b[7])) & (s[7] ^ a[7]);
                r.flags[`ALS_F_H] = hx[`ALS_H8_BIT];
                r.flags[`ALS_F_N] = sub; // RULE_12
                r.flags[`ALS_F_C] = s[8];
            end
        endcase
        return r;
    endfunction : alu8

    function automatic als_pkg::als_res_t rot8(input logic [2:0] k, input logic [7:0] v,
                                                input logic c);
        als_pkg::als_res_t r;
        case (k)
            `ALS_ROT_RLC: r.res = {v[6:0], v[7]};
            `ALS_ROT_RRC: r.res = {v[0], v[7:1]};
            `ALS_ROT_RL: r.res = {v[6:0], c};
            `ALS_ROT_RR: r.res = {c, v[7:1]};
            `ALS_ROT_SLA: r.res = {v[6:0], 1'b0};
            `ALS_ROT_SRA: r.res = {v[7], v[7:1]};
            `ALS_ROT_SLL: r.res = {v[6:0], 1'b1};
            default: r.res = {1'b0, v[7:1]};
        endcase
        r.flags = szp(r.res);
        r.flags[`ALS_F_C] = k[0] ? v[0] : v[7]; // RULE_18
        return r;
    endfunction : rot8

    function automatic logic [2:0] pair_tgt(input logic [1:0] p, input logic ui, input logic y);
        if (p == `ALS_PAIR_HL && ui)
            return y ? `ALS_T_IY : `ALS_T_IX;
        return {1'b0, p};
    endfunction : pair_tgt

    // byte stream routing
    wire take = byte_valid_i && byte_ready_o;
    wire idx = px || py;
    wire plain = !pe && !pb;
    wire use_idx = idx && !pe;
    wire is_pfx = plain && (byte_i == `ALS_PFX_X || byte_i == `ALS_PFX_Y ||
                            byte_i == `ALS_PFX_MISC || byte_i == `ALS_PFX_BIT);
    wire is_imm = plain && byte_i[7:6] == `ALS_GRP_IMM && byte_i[2:0] == `ALS_LO_IMM; // RULE_07
    wire is_mem = pb ? (idx || byte_i[2:0] == `ALS_SRC_MEM)
                : pe ? (byte_i == `ALS_OP_RRD || byte_i == `ALS_OP_RLD)
                : ((byte_i[7:6] == `ALS_GRP_ALU && byte_i[2:0] == `ALS_SRC_MEM) ||
                   (byte_i[7:6] == `ALS_GRP_MISC && byte_i[5:3] == `ALS_SRC_MEM &&
                    byte_i[2:1] == `ALS_LO_IDHI));
    wire op_take = take && state == als_pkg::S_OP && !is_pfx;
    wire ld_ok = ld_valid_i && state == als_pkg::S_OP && !byte_valid_i && !idx && plain;
    wire ex = state == als_pkg::S_EX;

    // operand addressing
    wire [15:0] hl = {r8[`ALS_IDX_H], r8[`ALS_IDX_L]};
    wire [15:0] idx_val = py ? iy : ix;
    wire [15:0] hl_eff = use_idx ? idx_val : hl;
    wire [7:0] d_now = (state == als_pkg::S_DISP) ? byte_i : disp;
    wire [15:0] disp_x = {{8{disp[7]}}, disp};
    wire [15:0] ea = use_idx ? idx_val + {{8{d_now[7]}}, d_now} : hl; // RULE_05
    wire [7:0] acc = r8[`ALS_IDX_A];
    wire [7:0] fl = r8[`ALS_IDX_F];

    // instruction classes
    wire c_alu = plain && (op[7:6] == `ALS_GRP_ALU ||
                           (op[7:6] == `ALS_GRP_IMM && op[2:0] == `ALS_LO_IMM)); // RULE_06
    wire c_id8 = plain && op[7:6] == `ALS_GRP_MISC && op[2:1] == `ALS_LO_IDHI; // RULE_08
    wire c_rota = plain && op[7:5] == `ALS_TOP_ROTA && op[2:0] == `ALS_LO_ROT; // RULE_21
    wire c_16 = plain && op[7:6] == `ALS_GRP_MISC;
    wire c_ed16 = pe && op[7:6] == `ALS_GRP_ED16;
    wire alu_sub = op[5:3] == `ALS_ALU_SUB || op[5:3] == `ALS_ALU_SBC ||
                   op[5:3] == `ALS_ALU_CMP;

    // source byte: memory or immediate in opnd, else register file
    wire [7:0] src8 = (op[2:0] == `ALS_SRC_MEM) ? opnd : r8[op[2:0]]; // RULE_20
    wire als_pkg::als_res_t ar = alu8(op[5:3], acc, src8, fl[`ALS_F_C]); // RULE_01
    wire als_pkg::als_res_t ng = alu8(`ALS_ALU_SUB, 8'h00, acc, 1'b0); // RULE_11
    wire als_pkg::als_res_t rr = rot8(op[5:3], pb ? src8 : acc, fl[`ALS_F_C]);

    // count up/down on register or memory byte
    wire id_mem = op[5:3] == `ALS_SRC_MEM;
    wire [7:0] id_v = id_mem ? opnd : r8[op[5:3]];
    wire [7:0] id_res = op[0] ? id_v - 8'h01 : id_v + 8'h01;
    wire [7:0] id_hx = id_v ^ id_res;

    // decimal correction steered by the subtract indicator
    wire bcd_lo = fl[`ALS_F_H] || acc[3:0] > `ALS_NIB_MAX;
    wire bcd_hi = fl[`ALS_F_C] || acc > `ALS_BYTE_MAX;
    wire [7:0] bcd_k = (bcd_hi ? `ALS_BCD_HI : 8'h00) | (bcd_lo ? `ALS_BCD_LO : 8'h00);
    wire [7:0] bcd_res = fl[`ALS_F_N] ? acc - bcd_k : acc + bcd_k; // RULE_13

    // digit rotates
    wire [7:0] rld_a = {acc[7:4], opnd[7:4]};
    wire [7:0] rld_m = {opnd[3:0], acc[3:0]};
    wire [7:0] rrd_a = {acc[7:4], opnd[3:0]};
    wire [7:0] rrd_m = {acc[3:0], opnd[7:4]};

    // 16-bit arithmetic
    wire [15:0] bc = {r8[`ALS_IDX_B], r8[`ALS_IDX_C]};
    wire [15:0] src16 = (op[5:4] == `ALS_PAIR_BC) ? bc
                      : (op[5:4] == `ALS_PAIR_DE) ? {r8[`ALS_IDX_D], r8[`ALS_IDX_E]}
                      : (op[5:4] == `ALS_PAIR_HL) ? hl_eff : sp;
    wire [16:0] s16_add = {1'b0, hl_eff} + {1'b0, src16}; // RULE_15
    wire [16:0] s16_c = op[3] ? {1'b0, hl} + {1'b0, src16} + {16'h0000, fl[`ALS_F_C]}
                              : {1'b0, hl} - {1'b0, src16} - {16'h0000, fl[`ALS_F_C]};
    wire [15:0] xa = hl_eff ^ src16 ^ s16_add[15:0];
    wire [15:0] xc = hl ^ src16 ^ s16_c[15:0];
    wire v16 = (op[3] ? ~(hl[15] ^ src16[15]) : (hl[15] ^ src16[15])) & (s16_c[15] ^ hl[15]);

    always_comb
    begin
        w8_en = 1'b0;
        w8_idx = `ALS_IDX_A;
        w8_val = ar.res;
        f_val = fl;
        w16_en = 1'b0;
        w16_t = pair_tgt(`ALS_PAIR_HL, use_idx, py);
        w16_val = s16_add[15:0];
        wm_en = 1'b0;
        wm_val = id_res;
        if (c_alu)
        begin
            w8_en = op[5:3] != `ALS_ALU_CMP; // RULE_02
            f_val = ar.flags; // RULE_03
        end
        else if (c_id8)
        begin
            wm_en = id_mem; // RULE_04
            w8_en = !id_mem;
            w8_idx = op[5:3];
            w8_val = id_res;
            f_val = szp(id_res);
            f_val[`ALS_F_PV] = op[0] ? id_v == `ALS_DEC_OVF : id_v == `ALS_INC_OVF;
            f_val[`ALS_F_H] = id_hx[`ALS_H8_BIT];
            f_val[`ALS_F_N] = op[0];
            f_val[`ALS_F_C] = fl[`ALS_F_C];
        end
        else if (pb)
        begin
            // bit test/set/reset are not decoded anywhere; only the shift quarter acts here
            if (op[7:6] == `ALS_GRP_MISC)
            begin
                wm_en = idx || op[2:0] == `ALS_SRC_MEM; // RULE_18
                w8_en = !wm_en;
                w8_idx = op[2:0];
                w8_val = rr.res;
                wm_val = rr.res;
                f_val = rr.flags;
            end
        end
        else if (c_rota)
        begin
            w8_en = 1'b1;
            w8_val = rr.res;
            f_val[`ALS_F_H] = 1'b0;
            f_val[`ALS_F_N] = 1'b0;
            f_val[`ALS_F_C] = rr.flags[`ALS_F_C];
        end
        else if (pe)
        begin
            if (op == `ALS_OP_NEG)
            begin
                w8_en = 1'b1; // RULE_10
                w8_val = ng.res;
                f_val = ng.flags;
            end
            else if (op == `ALS_OP_RLD || op == `ALS_OP_RRD)
            begin
                w8_en = 1'b1;
                w8_val = op[3] ? rld_a : rrd_a; // RULE_19
                wm_en = 1'b1;
                wm_val = op[3] ? rld_m : rrd_m;
                f_val = szp(w8_val);
                f_val[`ALS_F_C] = fl[`ALS_F_C];
            end
            else if (c_ed16 && (op[3:0] == `ALS_LO_ADC16 || op[3:0] == `ALS_LO_SBC16))
            begin
                w16_en = 1'b1; // RULE_16
                w16_t = `ALS_T_HL;
                w16_val = s16_c[15:0];
                f_val = 8'h00;
                f_val[`ALS_F_S] = s16_c[15];
                f_val[`ALS_F_Z] = s16_c[15:0] == 16'h0000;
                f_val[`ALS_F_H] = xc[`ALS_H16_BIT];
                f_val[`ALS_F_PV] = v16;
                f_val[`ALS_F_N] = !op[3];
                f_val[`ALS_F_C] = s16_c[16];
            end
        end
        else if (op == `ALS_OP_BCD)
        begin
            w8_en = 1'b1;
            w8_val = bcd_res;
            f_val = szp(bcd_res);
            f_val[`ALS_F_H] = fl[`ALS_F_N] ? (fl[`ALS_F_H] && acc[3:0] < `ALS_NIB_SIX)
                                           : (acc[3:0] > `ALS_NIB_MAX);
            f_val[`ALS_F_N] = fl[`ALS_F_N];
            f_val[`ALS_F_C] = bcd_hi;
        end
        else if (op == `ALS_OP_INV)
        begin
            w8_en = 1'b1;
            w8_val = ~acc;
            f_val[`ALS_F_H] = 1'b1;
            f_val[`ALS_F_N] = 1'b1;
        end
        else if (op == `ALS_OP_SCF || op == `ALS_OP_CCF)
        begin
            f_val[`ALS_F_H] = op[3] && fl[`ALS_F_C];
            f_val[`ALS_F_N] = 1'b0;
            f_val[`ALS_F_C] = !(op[3] && fl[`ALS_F_C]);
        end
        else if (c_16)
        begin
            w16_t = pair_tgt(op[5:4], use_idx, py); // RULE_17
            if (op[3:0] == `ALS_LO_ADD16)
            begin
                w16_en = 1'b1;
                w16_t = pair_tgt(`ALS_PAIR_HL, use_idx, py);
                f_val[`ALS_F_H] = xa[`ALS_H16_BIT];
                f_val[`ALS_F_N] = 1'b0;
                f_val[`ALS_F_C] = s16_add[16];
            end
            else if (op[3:0] == `ALS_LO_INC16 || op[3:0] == `ALS_LO_DEC16)
            begin
                w16_en = 1'b1;
                w16_val = op[3] ? src16 - 16'h0001 : src16 + 16'h0001;
            end
        end
    end

    always_comb
    begin
        next_state = state;
        next_px = px;
        next_py = py;
        next_pe = pe;
        next_pb = pb;
        case (state)
            als_pkg::S_OP:
                if (take && is_pfx)
                begin
                    // a later index prefix overrides an earlier one
                    next_px = (byte_i == `ALS_PFX_X) || (px && byte_i != `ALS_PFX_Y);
                    next_py = (byte_i == `ALS_PFX_Y) || (py && byte_i != `ALS_PFX_X);
                    next_pe = byte_i == `ALS_PFX_MISC;
                    next_pb = byte_i == `ALS_PFX_BIT;
                    if (byte_i == `ALS_PFX_BIT && idx)
                        next_state = als_pkg::S_DISP;
                end
                else if (take)
                begin
                    if (is_imm)
                        next_state = als_pkg::S_IMM;
                    else if (is_mem)
                        next_state = (idx && plain) ? als_pkg::S_DISP : als_pkg::S_RD;
                    else
                        next_state = als_pkg::S_EX;
                end
            als_pkg::S_DISP:
                if (take)
                    next_state = pb ? als_pkg::S_OP : als_pkg::S_RD;
            als_pkg::S_IMM:
                if (take)
                    next_state = als_pkg::S_EX;
            als_pkg::S_RD:
                if (mem_ack_i)
                    next_state = als_pkg::S_EX;
            als_pkg::S_EX:
            begin
                next_state = wm_en ? als_pkg::S_WR : als_pkg::S_OP;
                next_px = 1'b0;
                next_py = 1'b0;
                next_pe = 1'b0;
                next_pb = 1'b0;
            end
            als_pkg::S_WR:
                if (mem_ack_i)
                    next_state = als_pkg::S_OP;
            default: next_state = als_pkg::S_OP;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state <= als_pkg::S_OP;
            {px, py, pe, pb} <= 4'h0;
            byte_ready_o <= 1'b1;
            done_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            {px, py, pe, pb} <= {next_px, next_py, next_pe, next_pb};
            byte_ready_o <= next_state == als_pkg::S_OP || next_state == als_pkg::S_DISP ||
                            next_state == als_pkg::S_IMM;
            done_o <= (ex && !wm_en) || (state == als_pkg::S_WR && mem_ack_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            mem_o <= '0;
            {op, disp, opnd} <= 24'h000000;
        end
        else
        begin
            mem_o.req <= next_state == als_pkg::S_RD || next_state == als_pkg::S_WR;
            mem_o.wr <= next_state == als_pkg::S_WR;
            // write-back reuses the read address, so it is latched only on entry
            if (next_state == als_pkg::S_RD && state != als_pkg::S_RD)
                mem_o.addr <= ea;
            if (ex)
                mem_o.wdata <= wm_val;
            if (op_take)
                op <= byte_i;
            if (take && state == als_pkg::S_DISP)
                disp <= byte_i;
            if (take && state == als_pkg::S_IMM)
                opnd <= byte_i;
            else if (state == als_pkg::S_RD && mem_ack_i)
                opnd <= mem_rdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < 8; i++)
                r8[i] <= 8'h00;
            {sp, ix, iy} <= 48'h000000000000;
        end
        else if (ld_ok)
        begin
            case (ld_sel_i)
                `ALS_LD_SP: sp <= ld_data_i;
                `ALS_LD_IX: ix <= ld_data_i;
                `ALS_LD_IY: iy <= ld_data_i;
                default: if (!ld_sel_i[3]) r8[ld_sel_i[2:0]] <= ld_data_i[7:0];
            endcase
        end
        else if (ex)
        begin
            if (w8_en)
                r8[w8_idx] <= w8_val;
            r8[`ALS_IDX_F] <= f_val;
            if (w16_en)
                case (w16_t)
                    `ALS_T_BC: {r8[`ALS_IDX_B], r8[`ALS_IDX_C]} <= w16_val;
                    `ALS_T_DE: {r8[`ALS_IDX_D], r8[`ALS_IDX_E]} <= w16_val;
                    `ALS_T_HL: {r8[`ALS_IDX_H], r8[`ALS_IDX_L]} <= w16_val;
                    `ALS_T_SP: sp <= w16_val;
                    `ALS_T_IX: ix <= w16_val;
                    default: iy <= w16_val;
                endcase
        end
    end

    assign regs_o = {acc, fl, r8[`ALS_IDX_B], r8[`ALS_IDX_C], r8[`ALS_IDX_D],
                     r8[`ALS_IDX_E], r8[`ALS_IDX_H], r8[`ALS_IDX_L], sp, ix, iy};

    default clocking cb_clk @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_disp_in;
        state == als_pkg::S_DISP && take && !pb ##1 state == als_pkg::S_RD;
    endsequence

    a_alu_to_acc: assert property (ex && c_alu && op[5:3] != `ALS_ALU_CMP |=> acc == $past(ar.res)) // RULE_02
        else $error("alu result not in accumulator");
    a_cmp_keeps_acc: assert property (ex && c_alu && op[5:3] == `ALS_ALU_CMP |=> $stable(acc)) // RULE_02
        else $error("compare changed accumulator");
    a_alu_flags: assert property (ex && c_alu |=> fl == $past(ar.flags)) // RULE_03
        else $error("alu flags not updated");
    a_sub_indicator: assert property (ex && c_alu |=> fl[`ALS_F_N] == $past(alu_sub)) // RULE_12
        else $error("subtract indicator wrong");
    a_incdec_back: assert property (ex && c_id8 && id_mem |=> state == als_pkg::S_WR && mem_o.wr && mem_o.wdata == $past(id_res)) // RULE_04
        else $error("count result not written back");
    a_idx_addr: assert property (s_disp_in |-> mem_o.req && mem_o.addr == idx_val + disp_x) // RULE_05
        else $error("indexed address wrong");
    a_neg_twos: assert property (ex && pe && op == `ALS_OP_NEG |=> acc == (~$past(acc)) + 8'h01) // RULE_11
        else $error("sign flip not two's complement");
    a_and_self: assert property (ex && plain && op == `ALS_OP_AND_A |=> !fl[`ALS_F_C] && $stable(acc)) // RULE_14
        else $error("and with self kept carry");
    a_carry_set: assert property (ex && plain && op == `ALS_OP_SCF |=> fl[`ALS_F_C] ##1 done_o == 1'b0) // RULE_10
        else $error("carry not forced high");
    a_digit_wr: assert property (ex && pe && op == `ALS_OP_RLD |=> mem_o.wr ##1 mem_o.wdata == $past(rld_m, 2)) // RULE_19
        else $error("digit rotate memory byte wrong");
    a_pair_inc: assert property (ex && c_16 && op[5:4] == `ALS_PAIR_BC && op[3:0] == `ALS_LO_INC16 |=> bc == $past(bc) + 16'h0001) // RULE_17
        else $error("pair count up wrong");
endmodule : als_core

// [design/als_pkg.sv]
package als_pkg;
    typedef enum logic [2:0] {
        S_OP = 3'h0,
        S_DISP = 3'h1,
        S_RD = 3'h3,
        S_EX = 3'h2,
        S_WR = 3'h6,
        S_IMM = 3'h4
    } als_state_t;
    typedef struct packed {
        logic [7:0] res;
        logic [7:0] flags;
    } als_res_t;
    typedef struct packed {
        logic [7:0] a, f, b, c, d, e, h, l;
        logic [15:0] sp, ix, iy;
    } als_regs_t;
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } als_mem_t;
endpackage : als_pkg

// [verif/als_mem_model.sv]
`timescale 1ns/1ps
module als_mem_model (
    // clock and request
    input wire logic clk_i,
    input wire als_pkg::als_mem_t mem_i,
    input wire logic [1:0] lat_i,
    // answer
    output logic ack_o,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:255];
    logic [1:0] cnt = 2'h0;
    initial ack_o = 1'b0;
    initial rdata_o = 8'h00;
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        // idle bus toggles so stale data never passes
        rdata_o <= ~rdata_o;
        cnt <= 2'h0;
        if (mem_i.req && !ack_o && cnt != lat_i)
            cnt <= cnt + 2'h1;
        else if (mem_i.req && !ack_o)
        begin
            ack_o <= 1'b1;
            rdata_o <= mem[mem_i.addr[7:0]];
            if (mem_i.wr)
                mem[mem_i.addr[7:0]] <= mem_i.wdata;
        end
    end
endmodule : als_mem_model

// [verif/cpu_arith_logic_shift_unit_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module cpu_arith_logic_shift_unit_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic ld_valid_i = 1'b0;
    logic [3:0] ld_sel_i = 4'h0;
    logic [15:0] ld_data_i = 16'h0000;
    logic [1:0] lat = 2'h0;
    logic byte_ready_o, mem_ack_i, done_o;
    logic [7:0] mem_rdata_i;
    als_pkg::als_mem_t mem_o;
    als_pkg::als_regs_t r;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 clk_i = ~clk_i;
    als_core als_core_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
        .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .ld_valid_i(ld_valid_i), .ld_sel_i(ld_sel_i), .ld_data_i(ld_data_i),
        .regs_o(r), .done_o(done_o));
    als_mem_model als_mem_model_inst (.clk_i(clk_i), .mem_i(mem_o), .lat_i(lat),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    task print_verdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // preload stays asserted until the next instruction clears it
    task ld(input logic [3:0] s, input logic [15:0] d);
        #1 ld_valid_i = 1'b1;
        ld_sel_i = s;
        ld_data_i = d;
        @(posedge clk_i);
    endtask : ld
    task ex(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
        logic [7:0] q [3];
        int k;
        q = '{b0, b1, b2};
        #1 ld_valid_i = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            byte_valid_i = 1'b1;
            byte_i = q[i];
            // ready is read off the edge, so the taking edge is known
            while (byte_ready_o !== 1'b1)
            begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
            #1;
        end
        byte_valid_i = 1'b0;
        for (k = 0; k < 40 && done_o !== 1'b1; k++)
        begin
            @(posedge clk_i);
            #1;
        end
        `CHK(k < 40, 1'b1)
    endtask : ex
    task t_alu;
        ld(4'h7, 16'h003C);
        ex(2, 8'hC6, 8'h55);
        `CHK(r.a, 8'h91)
        ld(4'h7, 16'h00F3);
        ex(2, 8'hE6, 8'h07);
        `CHK(r.a, 8'h03)
        $display("test alu done");
    endtask : t_alu
    task t_bcd;
        ld(4'h7, 16'h0042);
        ld(4'h0, 16'h0015);
        ex(1, 8'hB8);
        `CHK({r.a, r.f[1]}, 9'h085)
        ex(1, 8'h90);
        ex(1, 8'h27);
        `CHK(r.a, 8'h27)
        ex(1, 8'h80);
        `CHK(r.f[1], 1'b0)
        ex(1, 8'h27);
        `CHK(r.a, 8'h42)
        $display("test bcd done");
    endtask : t_bcd
    task t_carry;
        ex(1, 8'h37);
        ex(1, 8'h3F);
        `CHK({r.f[4], r.f[0]}, 2'h2)
        ld(4'h7, 16'h0010);
        ex(1, 8'h37);
        ex(1, 8'hA7);
        `CHK({r.a, r.f[0]}, 9'h020)
        ex(1, 8'h2F);
        ex(2, 8'hED, 8'h44);
        `CHK(r.a, 8'h11)
        ex(1, 8'h37);
        ex(2, 8'hCE, 8'h05);
        `CHK(r.a, 8'h17)
        $display("test carry done");
    endtask : t_carry
    task t_mem;
        lat = 2'h2;
        als_mem_model_inst.mem[8'h40] = 8'h7F;
        als_mem_model_inst.mem[8'h4E] = 8'h10;
        ld(4'h4, 16'h0000);
        ld(4'h5, 16'h0040);
        ld(4'h7, 16'h0001);
        ld(4'h9, 16'h0050);
        ex(1, 8'h34);
        `CHK({als_mem_model_inst.mem[8'h40], r.f[2]}, 9'h101)
        ex(1, 8'h86);
        `CHK(r.a, 8'h81)
        ex(3, 8'hDD, 8'h35, 8'hFE);
        `CHK(als_mem_model_inst.mem[8'h4E], 8'h0F)
        $display("test mem done");
    endtask : t_mem
    task t_shift;
        als_mem_model_inst.mem[8'h40] = 8'h5A;
        ld(4'h0, 16'h0081);
        ex(2, 8'hCB, 8'h00);
        `CHK({r.b, r.f[0]}, 9'h007)
        ex(1, 8'h0F);
        `CHK({r.a, r.f[0]}, 9'h181)
        ex(2, 8'hED, 8'h6F);
        `CHK({r.a, als_mem_model_inst.mem[8'h40]}, 16'hC5A0)
        $display("test shift done");
    endtask : t_shift
    task t_wide;
        ld(4'h4, 16'h0012);
        ld(4'h5, 16'h0034);
        ld(4'h0, 16'h0001);
        ld(4'h1, 16'h00FF);
        ld(4'h9, 16'h0FFF);
        ex(1, 8'h09);
        `CHK({r.h, r.l}, 16'h1433)
        ex(1, 8'h03);
        `CHK({r.b, r.c}, 16'h0200)
        ex(2, 8'hED, 8'h42);
        `CHK({r.h, r.l, r.f[1]}, 17'h02467)
        ex(2, 8'hDD, 8'h23);
        ex(2, 8'hDD, 8'h29);
        `CHK(r.ix, 16'h2000)
        $display("test wide done");
    endtask : t_wide
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        t_alu;
        t_bcd;
        t_carry;
        t_mem;
        t_shift;
        t_wide;
        print_verdict;
    end
endmodule : cpu_arith_logic_shift_unit_tb
